// file: rtl/mpt_pkg.sv
package mpt_pkg;
   // ====
   // core clock and mii clock timing
   localparam int CORE_NS = 5;
   localparam int CLK_100_NS = 40;
   localparam int CLK_10_NS = 400;
   localparam logic [5:0] HALF_100 = 6'(CLK_100_NS / (2 * CORE_NS));
   localparam logic [5:0] HALF_10 = 6'(CLK_10_NS / (2 * CORE_NS));
   // ====
   // bit times
   localparam int BIT_100_NS = 10;
   localparam int BIT_10_NS = 100;
   localparam logic [4:0] BIT_CYC_100 = 5'(BIT_100_NS / CORE_NS);
   localparam logic [4:0] BIT_CYC_10 = 5'(BIT_10_NS / CORE_NS);
   localparam logic [1:0] NIB_LAST = 2'h3;
   // ====
   // management timing and frame layout
   localparam int MDIO_VALID_NS = 300;
   localparam int MDIO_VALID_CYC = MDIO_VALID_NS / CORE_NS;
   localparam logic [5:0] MG_PRE_ONES = 6'h20;
   localparam logic [5:0] MG_HDR_BITS = 6'h0d;
   localparam logic [5:0] MG_DATA_BITS = 6'h10;
   localparam logic [1:0] MG_OP_READ = 2'h2;
   localparam logic [4:0] PHY_ADDR_DEF = 5'h01;
   localparam int MG_ST_SPD = 15;
   localparam int MG_ST_HALF = 14;
   localparam int MG_ST_TX = 13;
   localparam int MG_ST_RX = 12;
   // ====
   // line side and buffering
   localparam logic [3:0] SSD_J_NIB = 4'h3;
   localparam int FIFO_W = 4;
   localparam int FIFO_D = 16;
   localparam int SYNC_W = 11;
   typedef enum logic [1:0] {
      MG_IDLE = 2'h0,
      MG_HDR = 2'h1,
      MG_TA = 2'h3,
      MG_DATA = 2'h2
   } mpt_mg_t;
endpackage

// file: rtl/mpt_sync3.sv
`timescale 1ns/10ps
module mpt_sync3
   import mpt_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } mpt_sync_t;
   mpt_sync_t st_r;
   mpt_sync_t st_nxt;
   // a bit is accepted only once the second and third stages agree
   always_comb begin
      st_nxt = st_r;
      st_nxt.s1 = i_async;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      st_nxt.q = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.q);
   end
   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   assign o_sync = st_r.q;
endmodule

// file: rtl/mpt_fifo.sv
`timescale 1ns/10ps
module mpt_fifo
   import mpt_pkg::*;
#(
   parameter int W = FIFO_W,
   parameter int D = FIFO_D
) (
   input wire logic i_wr_clk,
   input wire logic i_wr_rst_b,
   input wire logic i_wr_valid,
   output logic o_wr_ready,
   input wire logic [W-1:0] i_wr_data,
   input wire logic i_rd_clk,
   input wire logic i_rd_rst_b,
   output logic o_rd_valid,
   input wire logic i_rd_ready,
   output logic [W-1:0] o_rd_data
);
   localparam int AW = $clog2(D);
   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW:0] wp;
      logic [AW:0] wpg;
      logic [AW:0] rg1;
      logic [AW:0] rg2;
   } mpt_fw_t;
   typedef struct packed {
      logic [AW:0] rp;
      logic [AW:0] rpg;
      logic [AW:0] wg1;
      logic [AW:0] wg2;
      logic vld;
      logic [W-1:0] dat;
   } mpt_fr_t;
   mpt_fw_t w_r;
   mpt_fw_t w_nxt;
   mpt_fr_t r_r;
   mpt_fr_t r_nxt;
   logic full;
   logic empty;

   function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
      return b ^ (b >> 1);
   endfunction

   // ====
   // write side: only gray pointers cross, so a stale view is merely conservative
   assign full = (w_r.wpg == {~w_r.rg2[AW:AW-1], w_r.rg2[AW-2:0]});
   assign o_wr_ready = !full;
   always_comb begin
      w_nxt = w_r;
      w_nxt.rg1 = r_r.rpg;
      w_nxt.rg2 = w_r.rg1;
      if (i_wr_valid && !full) begin
         w_nxt.mem[w_r.wp[AW-1:0]] = i_wr_data;
         w_nxt.wp = w_r.wp + 1'b1;
         w_nxt.wpg = bin2gray(w_r.wp + 1'b1);
      end
   end
   always_ff @(posedge i_wr_clk or negedge i_wr_rst_b) begin
      if (!i_wr_rst_b) begin
         w_r <= '0;
      end else begin
         w_r <= w_nxt;
      end
   end

   // ====
   // read side: data leave through an output register
   assign empty = (r_r.rpg == r_r.wg2);
   always_comb begin
      r_nxt = r_r;
      r_nxt.wg1 = w_r.wpg;
      r_nxt.wg2 = r_r.wg1;
      if (!r_r.vld || i_rd_ready) begin
         r_nxt.vld = !empty;
         if (!empty) begin
            r_nxt.dat = w_r.mem[r_r.rp[AW-1:0]];
            r_nxt.rp = r_r.rp + 1'b1;
            r_nxt.rpg = bin2gray(r_r.rp + 1'b1);
         end
      end
   end
   always_ff @(posedge i_rd_clk or negedge i_rd_rst_b) begin
      if (!i_rd_rst_b) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end
   assign o_rd_valid = r_r.vld;
   assign o_rd_data = r_r.dat;
endmodule

// file: rtl/mpt_mii_phy.sv
`timescale 1ns/10ps
module mpt_mii_phy
   import mpt_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR = PHY_ADDR_DEF
) (
   input wire logic i_core_clk,
   input wire logic i_rst_b,
   input wire logic i_line_clk,
   input wire logic i_speed_100,
   input wire logic i_half_duplex,
   input wire logic [3:0] i_txd,
   input wire logic i_tx_en,
   input wire logic i_tx_er,
   output logic o_tx_clk,
   output logic o_rx_clk,
   output logic [3:0] o_rxd,
   output logic o_rx_dv,
   output logic o_rx_er,
   output logic o_crs,
   input wire logic i_mdc,
   input wire logic i_mdio_in,
   output logic o_mdio_out,
   output logic o_mdio_oe,
   input wire logic i_line_receive_pair,
   input wire logic i_line_receive_dv,
   output logic o_line_transmit_pair,
   output logic o_line_transmit_en,
   output logic o_line_transmit_err
);
   // ====
   // state
   typedef struct packed {
      logic [3:0] sr;
      logic [1:0] cnt;
      logic pend;
      logic [3:0] pw;
   } mpt_link_t;

   typedef struct packed {
      logic [5:0] txdiv;
      logic txclk;
      logic [2:0] rise_d;
      logic [5:0] rxdiv;
      logic rxclk;
      logic tx_act;
      logic [3:0] tx_sr;
      logic [1:0] tx_n;
      logic [4:0] tx_bt;
      logic tx_err;
      logic txen_q;
      logic crs;
      logic [3:0] rxd;
      logic rx_dv;
      logic rx_er;
      logic rx_act;
      mpt_mg_t mg;
      logic [5:0] mg_cnt;
      logic [15:0] mg_sr;
      logic mdio_o;
      logic mdio_oe;
      logic mdc_q;
   } mpt_core_t;

   mpt_link_t l_r;
   mpt_link_t l_nxt;
   mpt_core_t s_r;
   mpt_core_t s_nxt;

   logic [SYNC_W-1:0] pins_s;
   logic spd_s;
   logic half_s;
   logic [3:0] txd_s;
   logic txen_s;
   logic txer_s;
   logic mdc_s;
   logic mdio_s;
   logic line_dv_s;
   logic fifo_wr_ready;
   logic fifo_vld;
   logic fifo_rdy;
   logic [3:0] fifo_dat;
   logic [5:0] half;
   logic [4:0] bitc;
   logic tx_rise;
   logic take;
   logic rx_fall;
   logic restart;
   logic launch;
   logic mdc_rise;
   logic [12:0] hdr;
   logic [15:0] stat;

   // ====
   // pin synchronisers
   mpt_sync3 #(
      .W(SYNC_W)
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_async({i_speed_100, i_half_duplex, i_txd, i_tx_en, i_tx_er, i_mdc, i_mdio_in, i_line_receive_dv}),
      .o_sync(pins_s)
   );
   assign {spd_s, half_s, txd_s, txen_s, txer_s, mdc_s, mdio_s, line_dv_s} = pins_s;

   // ====
   // link side: bits arrive lsb first and are packed into nibbles
   always_comb begin
      l_nxt = l_r;
      if (l_r.pend && fifo_wr_ready) begin
         l_nxt.pend = 1'b0;
      end
      if (i_line_receive_dv) begin
         l_nxt.sr = {i_line_receive_pair, l_r.sr[3:1]};
         l_nxt.cnt = l_r.cnt + 1'b1;
         // a full buffer holds the pending nibble; a nibble completed behind it is lost
         if (l_r.cnt == NIB_LAST && !l_nxt.pend) begin
            l_nxt.pw = {i_line_receive_pair, l_r.sr[3:1]};
            l_nxt.pend = 1'b1;
         end
      end else begin
         l_nxt.cnt = 2'h0;
      end
   end
   always_ff @(posedge i_line_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         l_r <= '0;
      end else begin
         l_r <= l_nxt;
      end
   end

   mpt_fifo #(
      .W(FIFO_W),
      .D(FIFO_D)
   ) u_fifo (
      .i_wr_clk(i_line_clk),
      .i_wr_rst_b(i_rst_b),
      .i_wr_valid(l_r.pend),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(l_r.pw),
      .i_rd_clk(i_core_clk),
      .i_rd_rst_b(i_rst_b),
      .o_rd_valid(fifo_vld),
      .i_rd_ready(fifo_rdy),
      .o_rd_data(fifo_dat)
   );

   // ====
   // core side
   assign half = spd_s ? HALF_100 : HALF_10;
   assign bitc = spd_s ? BIT_CYC_100 : BIT_CYC_10;
   assign tx_rise = (s_r.txdiv >= half - 6'h01) && !s_r.txclk;
   assign take = s_r.rise_d[2];
   assign rx_fall = s_r.rxclk && (s_r.rxdiv >= half - 6'h01);
   // the first nibble of a frame need not wait a whole rx clock period
   assign restart = !s_r.rxclk && !s_r.rx_act && fifo_vld;
   assign launch = rx_fall || restart;
   assign fifo_rdy = launch;
   assign mdc_rise = mdc_s && !s_r.mdc_q;
   assign hdr = {s_r.mg_sr[11:0], mdio_s};

   always_comb begin
      stat = 16'h0000;
      stat[MG_ST_SPD] = spd_s;
      stat[MG_ST_HALF] = half_s;
      stat[MG_ST_TX] = s_r.tx_act;
      stat[MG_ST_RX] = s_r.rx_act;
   end

   always_comb begin
      s_nxt = s_r;
      // clocks are divided from the core clock; a speed change does not restart them, the running phase ends against the new half count
      s_nxt.txdiv = s_r.txdiv + 6'h01;
      if (s_r.txdiv >= half - 6'h01) begin
         s_nxt.txdiv = 6'h00;
         s_nxt.txclk = !s_r.txclk;
      end
      s_nxt.rise_d = {s_r.rise_d[1:0], tx_rise};
      s_nxt.rxdiv = s_r.rxdiv + 6'h01;
      if (s_r.rxdiv >= half - 6'h01 && !restart) begin
         s_nxt.rxdiv = 6'h00;
         s_nxt.rxclk = !s_r.rxclk;
      end
      // a restart only stretches a low phase, never shortens a high one
      if (restart) begin
         s_nxt.rxdiv = 6'h00;
      end

      // receive data change only in a low phase: at its start, or at a restart within it
      if (launch) begin
         if (fifo_vld) begin
            s_nxt.rxd = fifo_dat;
            s_nxt.rx_dv = 1'b1;
            s_nxt.rx_act = 1'b1;
            s_nxt.rx_er = 1'b0;
         end else if (s_r.rx_act && line_dv_s) begin
            s_nxt.rx_er = 1'b1;
         end else begin
            s_nxt.rx_dv = 1'b0;
            s_nxt.rx_act = 1'b0;
            s_nxt.rx_er = 1'b0;
         end
      end

      // transmit serialiser, one bit per bit time
      if (s_r.tx_act) begin
         if (s_r.tx_bt >= bitc - 5'h01) begin
            s_nxt.tx_bt = 5'h00;
            s_nxt.tx_sr = {1'b0, s_r.tx_sr[3:1]};
            s_nxt.tx_n = s_r.tx_n + 1'b1;
            if (s_r.tx_n == NIB_LAST) begin
               s_nxt.tx_act = 1'b0;
            end
         end else begin
            s_nxt.tx_bt = s_r.tx_bt + 5'h01;
         end
      end
      if (take) begin
         s_nxt.txen_q = txen_s;
         if (txen_s) begin
            s_nxt.tx_act = 1'b1;
            s_nxt.tx_bt = 5'h00;
            s_nxt.tx_n = 2'h0;
            s_nxt.tx_err = txer_s;
            s_nxt.tx_sr = txd_s;
            // at 100M the opening nibble is replaced by the stream start marker
            if (spd_s && !s_r.txen_q) begin
               s_nxt.tx_sr = SSD_J_NIB;
            end
         end
      end

      // carrier follows the sampled enable in half duplex and any receive activity
      s_nxt.crs = (half_s && s_nxt.txen_q) || line_dv_s || s_r.rx_act;

      // management: answer reads only, any register returns the status word
      s_nxt.mdc_q = mdc_s;
      if (mdc_rise) begin
         case (s_r.mg)
            MG_IDLE: begin
               if (mdio_s) begin
                  if (s_r.mg_cnt != MG_PRE_ONES) begin
                     s_nxt.mg_cnt = s_r.mg_cnt + 6'h01;
                  end
               end else begin
                  if (s_r.mg_cnt == MG_PRE_ONES) begin
                     s_nxt.mg = MG_HDR;
                  end
                  s_nxt.mg_cnt = 6'h00;
               end
            end
            MG_HDR: begin
               s_nxt.mg_sr = {s_r.mg_sr[14:0], mdio_s};
               s_nxt.mg_cnt = s_r.mg_cnt + 6'h01;
               if (s_r.mg_cnt == MG_HDR_BITS - 6'h01) begin
                  s_nxt.mg_cnt = 6'h00;
                  if (hdr[12] && hdr[11:10] == MG_OP_READ && hdr[9:5] == PHY_ADDR) begin
                     s_nxt.mg = MG_TA;
                  end else begin
                     s_nxt.mg = MG_IDLE;
                  end
               end
            end
            MG_TA: begin
               s_nxt.mdio_oe = 1'b1;
               s_nxt.mdio_o = 1'b0;
               s_nxt.mg_sr = stat;
               s_nxt.mg = MG_DATA;
            end
            MG_DATA: begin
               if (s_r.mg_cnt == MG_DATA_BITS) begin
                  s_nxt.mdio_oe = 1'b0;
                  s_nxt.mg_cnt = 6'h00;
                  s_nxt.mg = MG_IDLE;
               end else begin
                  s_nxt.mdio_o = s_r.mg_sr[15];
                  s_nxt.mg_sr = {s_r.mg_sr[14:0], 1'b0};
                  s_nxt.mg_cnt = s_r.mg_cnt + 6'h01;
               end
            end
            default: begin
               s_nxt.mg = MG_IDLE;
               s_nxt.mdio_oe = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ====
   // outputs
   assign o_tx_clk = s_r.txclk;
   assign o_rx_clk = s_r.rxclk;
   assign o_rxd = s_r.rxd;
   assign o_rx_dv = s_r.rx_dv;
   assign o_rx_er = s_r.rx_er;
   assign o_crs = s_r.crs;
   assign o_mdio_out = s_r.mdio_o;
   assign o_mdio_oe = s_r.mdio_oe;
   assign o_line_transmit_pair = s_r.tx_sr[0];
   assign o_line_transmit_en = s_r.tx_act;
   assign o_line_transmit_err = s_r.tx_err && s_r.tx_act;

   // ====
   // checks
   a_txclk_fast: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_tx_clk) && spd_s |-> ##4 $fell(o_tx_clk) ##4 $rose(o_tx_clk))
      else $error("tx clock period wrong at 100M");

   a_txclk_slow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_tx_clk) && !spd_s |-> ##40 $fell(o_tx_clk) ##40 $rose(o_tx_clk))
      else $error("tx clock period wrong at 10M");

   a_rxclk_high_fast: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_rx_clk) && spd_s |-> o_rx_clk[*4] ##1 !o_rx_clk)
      else $error("rx clock high phase wrong at 100M");

   a_rxclk_high_slow: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $rose(o_rx_clk) && !spd_s |-> ##39 o_rx_clk ##1 !o_rx_clk)
      else $error("rx clock high phase wrong at 10M");

   a_rxd_low_phase: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $changed(o_rxd) || $changed(o_rx_dv) |-> !o_rx_clk)
      else $error("receive data changed in high phase");

   a_tx_take_edge: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take |-> $past(o_tx_clk, 2) && !$past(o_tx_clk, 3))
      else $error("transmit sample not tied to tx clock rise");

   a_tx_start_line: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take && txen_s && spd_s && !s_r.txen_q |=> o_line_transmit_en && o_line_transmit_pair == SSD_J_NIB[0])
      else $error("start marker not on line in time");

   a_crs_assert: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take && txen_s && half_s |=> o_crs)
      else $error("carrier not raised with transmit enable");

   a_crs_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      take && !txen_s && !line_dv_s && !s_r.rx_act |=> !o_crs)
      else $error("carrier held after transmit enable fell");

   a_mdio_update: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      $changed(o_mdio_out) || $changed(o_mdio_oe) |-> $past(mdc_rise))
      else $error("mdio changed away from mdc rise");

   a_mdio_turn: assert property (@(posedge i_core_clk) disable iff (!i_rst_b)
      s_r.mg == MG_TA && mdc_rise |=> o_mdio_oe && !o_mdio_out)
      else $error("turnaround zero not driven");
endmodule

// file: bench/mpt_sta.sv
`timescale 1ns/10ps
// ====
// station manager: makes mdc, sends a request, reads the reply
module mpt_sta
   import mpt_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_start,
   input wire logic [11:0] i_req,
   input wire logic i_mdio_wire,
   input wire logic i_mdio_oe,
   output logic o_mdc,
   output logic o_mdio,
   output logic [15:0] o_word,
   output logic o_oe_seen,
   output logic o_done
);
   logic [45:0] frame;
   initial begin
      o_mdc = 1'b0;
      o_mdio = 1'b1;
      o_word = 16'h0000;
      o_oe_seen = 1'b0;
      o_done = 1'b0;
   end
   always @(posedge i_start) begin
      frame = {32'hffff_ffff, 2'h1, i_req};
      o_done <= 1'b0;
      o_oe_seen <= 1'b0;
      for (int r = 0; r < 66; r++) begin
         @(negedge i_core_clk);
         // released line reads as the pull-up, so a silent device returns ones
         o_mdio <= (r < 46) ? frame[45 - r] : 1'b1;
         repeat (40) @(negedge i_core_clk);
         o_mdc <= 1'b1;
         // sample late in the high phase: anything slower than 300 ns is caught
         repeat (60) @(negedge i_core_clk);
         // the late sample sees the data bit launched by this same rise
         if (r >= 47 && r < 63) begin
            o_word[62 - r] <= i_mdio_wire;
         end
         if (i_mdio_oe === 1'b1) begin
            o_oe_seen <= 1'b1;
         end
         o_mdc <= 1'b0;
      end
      o_done <= 1'b1;
   end
endmodule

// file: bench/mii_phy_side_timing_test.sv
`timescale 1ns/10ps
module mii_phy_side_timing_test
   import mpt_pkg::*;
;
   localparam int CYC_MAX = 60000;
   logic clk, rst_b, line_clk, line_run, spd, half, tx_en, tx_er, line_bit, line_dv, sta_go, sel;
   logic tx_clk, rx_clk, rx_dv, rx_er, crs, mdio_out, mdio_oe, lt_pair, lt_en, lt_err;
   logic mdc, sta_mdio, mdio_wire, oe_seen, sta_done, mclk, dv_prev;
   logic [3:0] txd, rxd, rxd_prev;
   logic [11:0] req;
   logic [15:0] word;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   assign mdio_wire = mdio_oe ? mdio_out : sta_mdio;
   assign mclk = sel ? rx_clk : tx_clk;
   // ====
   // clocks
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // link clock stands still between frames
   initial begin
      line_clk = 1'b0;
      #3.3;
      forever begin
         #16;
         line_clk = line_run ? ~line_clk : 1'b0;
      end
   end
   always @(negedge clk) begin
      rxd_prev <= rxd;
      dv_prev <= rx_dv;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == CYC_MAX) begin
         bad_count++;
         close_out();
      end
   end
   // ====
   // design and partner
   mpt_mii_phy DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_line_clk(line_clk), .i_speed_100(spd),
      .i_half_duplex(half), .i_txd(txd), .i_tx_en(tx_en), .i_tx_er(tx_er), .o_tx_clk(tx_clk),
      .o_rx_clk(rx_clk), .o_rxd(rxd), .o_rx_dv(rx_dv), .o_rx_er(rx_er), .o_crs(crs), .i_mdc(mdc),
      .i_mdio_in(mdio_wire), .o_mdio_out(mdio_out), .o_mdio_oe(mdio_oe), .i_line_receive_pair(line_bit),
      .i_line_receive_dv(line_dv), .o_line_transmit_pair(lt_pair), .o_line_transmit_en(lt_en),
      .o_line_transmit_err(lt_err));
   mpt_sta sta (.i_core_clk(clk), .i_start(sta_go), .i_req(req), .i_mdio_wire(mdio_wire),
      .i_mdio_oe(mdio_oe), .o_mdc(mdc), .o_mdio(sta_mdio), .o_word(word), .o_oe_seen(oe_seen),
      .o_done(sta_done));
   // ====
   // compare and report
   task automatic cmp_v(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic cmp_max(input int got, input int lim, input string what);
      checks++;
      if (got > lim) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s %0d above %0d", $time, what, got, lim);
      end
   endtask
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", bad_count, checks);
      if (bad_count == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // straps only change under reset
   task automatic do_reset(input logic s, input logic h);
      @(negedge clk);
      rst_b = 1'b0;
      line_run = 1'b1;
      spd = s;
      half = h;
      repeat (10) @(negedge clk);
      rst_b = 1'b1;
      line_run = 1'b0;
      repeat (60) @(negedge clk);
   endtask
   // ====
   // scenarios
   task automatic t_clocks(input int per);
      real t0, t1, t2;
      for (int w = 0; w < 2; w++) begin
         sel = w[0];
         @(negedge clk);
         @(posedge mclk);
         t0 = $realtime;
         @(negedge mclk);
         t1 = $realtime;
         @(posedge mclk);
         t2 = $realtime;
         cmp_v(16'(int'(t2 - t0)), 16'(per), "clock period");
         cmp_v(16'(int'(t1 - t0)), 16'(per / 2), "clock high time");
      end
   endtask
   task automatic t_tx(input logic s);
      int bc, n, c, k;
      logic [7:0] got;
      logic e;
      bc = s ? int'(BIT_CYC_100) : int'(BIT_CYC_10);
      @(negedge tx_clk);
      @(negedge clk);
      tx_en = 1'b1;
      txd = 4'ha;
      @(posedge tx_clk);
      fork
         begin
            @(negedge tx_clk);
            @(negedge clk);
            txd = 4'h6;
            tx_er = 1'b1;
            @(negedge tx_clk);
            @(negedge clk);
            tx_en = 1'b0;
            txd = 4'h0;
            tx_er = 1'b0;
            @(posedge tx_clk);
            for (k = 0; k < 100 && crs !== 1'b0; k++) @(negedge clk);
            if (s) cmp_max(k, 4 * bc, "carrier release");
         end
         begin
            for (c = 0; c < 100 && crs !== 1'b1; c++) @(negedge clk);
            if (s) cmp_max(c, 4 * bc, "carrier rise");
            else cmp_v(16'(c), 16'h0064, "carrier in full duplex");
         end
         begin
            for (n = 0; n < 100 && lt_en !== 1'b1; n++) @(negedge clk);
            cmp_max(n, (s ? 3 : 2) * bc, "first line bit");
            for (int b = 0; b < 8; b++) begin
               got[b] = lt_pair;
               if (b == 5) e = lt_err;
               repeat (bc) @(negedge clk);
            end
            cmp_v(got, {4'h6, s ? SSD_J_NIB : 4'ha}, "line nibbles");
            cmp_v(e, 1'b1, "line error flag");
         end
      join
   endtask
   // 32 nibbles at the link rate overrun the 16-deep buffer at the 10M drain rate
   task automatic t_rx();
      int rcv;
      real tf;
      logic [3:0] q[$];
      rcv = 0;
      fork
         begin
            line_run = 1'b1;
            for (int i = 0; i < 128; i++) begin
               @(negedge line_clk);
               line_dv = 1'b1;
               line_bit = 1'((i / 4) >> (i % 4));
            end
            @(negedge line_clk);
            line_dv = 1'b0;
            line_bit = ~line_bit;
            @(negedge line_clk);
            line_run = 1'b0;
         end
         begin
            @(posedge line_clk iff line_dv === 1'b1);
            tf = $realtime;
            for (int k = 0; k < 80 && !(rcv > 0 && dv_prev !== 1'b1); k++) begin
               @(posedge rx_clk);
               if (dv_prev === 1'b1) begin
                  if (rcv == 0) cmp_max(int'($realtime - tf), 7 * BIT_10_NS, "receive latency");
                  q.push_back(rxd_prev);
                  rcv++;
                  cmp_v(rx_er, 1'b0, "receive error");
                  @(negedge clk);
                  cmp_v(rxd, q[$], "rxd hold after rise");
               end
            end
         end
      join
      for (int i = 0; i < 8; i++) cmp_v(q[i], 4'(i), "received nibble");
      cmp_max(rcv, 31, "nibbles kept past a full buffer");
      cmp_max(FIFO_D, rcv, "nibbles kept in buffer");
   endtask
   task automatic t_mdio();
      logic [11:0] rq[3];
      logic [15:0] ew[3];
      int k;
      rq = '{{MG_OP_READ, PHY_ADDR_DEF, 5'h01}, {MG_OP_READ, PHY_ADDR_DEF + 5'h01, 5'h01},
         {2'h1, PHY_ADDR_DEF, 5'h00}};
      ew = '{{spd, half, 14'h0000}, 16'hffff, 16'hffff};
      for (int i = 0; i < 3; i++) begin
         @(negedge clk);
         req = rq[i];
         sta_go = 1'b1;
         @(negedge clk);
         sta_go = 1'b0;
         for (k = 0; k < 8000 && sta_done !== 1'b1; k++) @(negedge clk);
         cmp_v(word, ew[i], "management word");
         cmp_v(oe_seen, i == 0, "management drive");
      end
   endtask
   // ====
   // main sequence
   initial begin
      rst_b = 1'b0;
      spd = 1'b1;
      half = 1'b1;
      tx_en = 1'b0;
      tx_er = 1'b0;
      txd = 4'h0;
      line_bit = 1'b0;
      line_dv = 1'b0;
      line_run = 1'b1;
      sta_go = 1'b0;
      sel = 1'b0;
      req = 12'h000;
      do_reset(1'b1, 1'b1);
      t_clocks(CLK_100_NS);
      t_tx(1'b1);
      t_mdio();
      do_reset(1'b0, 1'b0);
      t_clocks(CLK_10_NS);
      t_tx(1'b0);
      t_rx();
      t_mdio();
      close_out();
   end
endmodule
